// ### common/icm_pkg.sv
package icm_pkg;

  // ----------------------------------------------------------------------
  // Register map (word index on the register port)
  // ----------------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_DATA   = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_MASK   = 3'h3;
  localparam logic [2:0] ADDR_BRH    = 3'h4;
  localparam logic [2:0] ADDR_BRL    = 3'h5;
  localparam logic [2:0] ADDR_MODE   = 3'h6;

  // ----------------------------------------------------------------------
  // i2c_control fields
  // ----------------------------------------------------------------------
  localparam int CTL_EN    = 7;
  localparam int CTL_START = 6;
  localparam int CTL_STOP  = 5;
  localparam int CTL_BAUD_TIMER_IRQ_ENABLE  = 4;
  localparam int CTL_TXI   = 3;
  localparam int CTL_NAK   = 2;
  localparam int CTL_FLUSH = 1;
  localparam int CTL_FEN   = 0;

  // ----------------------------------------------------------------------
  // Status / mask fields and other bits
  // ----------------------------------------------------------------------
  localparam int ST_BAUD     = 0;
  localparam int ST_NAK_RX   = 1;
  localparam int ST_STOP_DN  = 2;
  localparam int ST_START_DN = 3;
  localparam int ST_TRANSMIT_EMPTY_FLAG     = 4;
  localparam int MODE_RX     = 0;
  localparam int EV_W        = 4;

  // ----------------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------------
  localparam logic [15:0] BRG_RESET  = 16'hffff;
  localparam logic [15:0] BRG_ONE    = 16'h0001;
  localparam logic [2:0]  LAST_BIT   = 3'h7;
  localparam logic [2:0]  FILT_DELAY = 3'h3;

  // ----------------------------------------------------------------------
  // Bus engine states
  // ----------------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE     = 7'b0000001,
    ST_START    = 7'b0000010,
    ST_BITS     = 7'b0000100,
    ST_ACK      = 7'b0001000,
    ST_HOLD     = 7'b0010000,
    ST_STOP     = 7'b0100000,
    ST_STOP_END = 7'b1000000
  } icm_state_t;

endpackage : icm_pkg

// ### verilog/icm_ctrl.sv
// Design decisions made here: the address-and-strobe port and the register addresses.
module icm_ctrl #(
  parameter int BRG_W = 16
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  output logic            irq,
  output logic            dma_tx_req
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    icm_pkg::icm_state_t st;
    logic                ph;
    logic [2:0]          bitcnt;
    logic [7:0]          shift;
    logic [7:0]          data;
    logic [7:0]          rx_byte;
    logic                transmit_empty_flag;
    logic                en;
    logic                start;
    logic                stop;
    logic                baud_timer_irq_enable;
    logic                transmit_interrupt_enable;
    logic                nak;
    logic                fen;
    logic                rx;
    logic [icm_pkg::EV_W-1:0] status;
    logic [icm_pkg::EV_W-1:0] mask;
    logic [BRG_W-1:0]    brg;
    logic [BRG_W-1:0]    cnt;
    logic [1:0]          sda_s;
    logic [1:0]          scl_s;
    logic [1:0]          sda_h;
    logic [1:0]          scl_h;
    logic                sda_q;
    logic                scl_q;
    logic [7:0]          rdata;
    logic                sda_oe;
    logic                scl_oe;
    logic                irq;
    logic                dma;
  } icm_regs_t;

  localparam icm_regs_t RESET_VAL = '{
    st:      icm_pkg::ST_IDLE,
    transmit_empty_flag:    1'b1,
    brg:     BRG_W'(icm_pkg::BRG_RESET),
    cnt:     BRG_W'(icm_pkg::BRG_RESET),
    sda_s:   2'h3,
    scl_s:   2'h3,
    sda_h:   2'h3,
    scl_h:   2'h3,
    sda_q:   1'b1,
    scl_q:   1'b1,
    default: '0
  };

  icm_regs_t r_reg;
  icm_regs_t r_next;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic                     tick;
    logic                     sda_f;
    logic [icm_pkg::EV_W-1:0] ev;
    logic [icm_pkg::EV_W-1:0] clr;
    r_next = r_reg;
    tick   = 1'b0;
    sda_f  = 1'b1;
    ev     = '0;
    clr    = '0;
    r_next.rdata = 8'h00;

    // Pin synchronisers; only the second stage is read by logic
    r_next.sda_s = {r_reg.sda_s[0], sda_i};
    r_next.scl_s = {r_reg.scl_s[0], scl_i};

    // A level must be seen on two samples in a row before it passes, so a
    // single-clock glitch never reaches the engine
    r_next.sda_h = {r_reg.sda_h[0], r_reg.sda_s[1]};
    r_next.scl_h = {r_reg.scl_h[0], r_reg.scl_s[1]};
    if (r_reg.sda_h[0] == r_reg.sda_h[1]) begin
      r_next.sda_q = r_reg.sda_h[1];
    end
    if (r_reg.scl_h[0] == r_reg.scl_h[1]) begin
      r_next.scl_q = r_reg.scl_h[1];
    end
    sda_f = r_reg.fen ? r_reg.sda_q : r_reg.sda_s[1];

    // Baud generator: one tick each time the count reaches one
    tick = (r_reg.cnt <= BRG_W'(icm_pkg::BRG_ONE));
    if (tick) begin
      r_next.cnt = r_reg.brg;
    end else begin
      r_next.cnt = r_reg.cnt - BRG_W'(icm_pkg::BRG_ONE);
    end
    ev[icm_pkg::ST_BAUD] = tick && !r_reg.en && r_reg.baud_timer_irq_enable;

    // ----------------------------------------------------------------------
    // Bus engine, one half bit per tick
    // ----------------------------------------------------------------------
    case (r_reg.st)
      icm_pkg::ST_IDLE: begin
        r_next.sda_oe = 1'b0;
        r_next.scl_oe = 1'b0;
        r_next.ph     = 1'b0;
        if (r_reg.start && !r_reg.transmit_empty_flag) begin
          r_next.st = icm_pkg::ST_START;
        end
      end
      icm_pkg::ST_START: begin
        if (tick) begin
          if (!r_reg.ph) begin
            r_next.sda_oe = 1'b0;
            r_next.scl_oe = 1'b0;
            r_next.ph     = 1'b1;
          end else begin
            r_next.sda_oe = 1'b1;
            r_next.start  = 1'b0;
            r_next.shift  = r_reg.data;
            r_next.transmit_empty_flag   = 1'b1;
            r_next.bitcnt = 3'h0;
            r_next.ph     = 1'b0;
            r_next.st     = icm_pkg::ST_BITS;
            ev[icm_pkg::ST_START_DN] = 1'b1;
          end
        end
      end
      icm_pkg::ST_BITS: begin
        if (tick) begin
          if (!r_reg.ph) begin
            r_next.scl_oe = 1'b1;
            r_next.sda_oe = r_reg.rx ? 1'b0 : !r_reg.shift[7];
            r_next.ph     = 1'b1;
          end else begin
            r_next.scl_oe = 1'b0;
            r_next.shift  = {r_reg.shift[6:0], sda_f};
            r_next.bitcnt = r_reg.bitcnt + 3'h1;
            r_next.ph     = 1'b0;
            if (r_reg.bitcnt == icm_pkg::LAST_BIT) begin
              r_next.st = icm_pkg::ST_ACK;
            end
          end
        end
      end
      icm_pkg::ST_ACK: begin
        if (tick) begin
          if (!r_reg.ph) begin
            r_next.scl_oe = 1'b1;
            r_next.sda_oe = r_reg.rx && !r_reg.nak;
            r_next.ph     = 1'b1;
          end else begin
            r_next.scl_oe = 1'b0;
            r_next.ph     = 1'b0;
            r_next.st     = icm_pkg::ST_HOLD;
            if (r_reg.rx) begin
              r_next.rx_byte = r_reg.shift;
              r_next.nak     = 1'b0;
            end else begin
              ev[icm_pkg::ST_NAK_RX] = sda_f;
            end
          end
        end
      end
      icm_pkg::ST_HOLD: begin
        // Byte and acknowledge are over; a pending stop acts only here, a pending start here or in ST_IDLE
        if (tick) begin
          r_next.scl_oe = 1'b1;
          r_next.sda_oe = 1'b0;
          r_next.bitcnt = 3'h0;
          if (r_reg.stop) begin
            r_next.st = icm_pkg::ST_STOP;
          end else if (r_reg.start) begin
            if (!r_reg.transmit_empty_flag) begin
              r_next.st = icm_pkg::ST_START;
            end
          end else if (r_reg.rx) begin
            r_next.st = icm_pkg::ST_BITS;
          end else if (!r_reg.transmit_empty_flag) begin
            r_next.shift = r_reg.data;
            r_next.transmit_empty_flag  = 1'b1;
            r_next.st    = icm_pkg::ST_BITS;
          end
        end
      end
      icm_pkg::ST_STOP: begin
        if (tick) begin
          if (!r_reg.ph) begin
            r_next.scl_oe = 1'b1;
            r_next.sda_oe = 1'b1;
            r_next.ph     = 1'b1;
          end else begin
            r_next.scl_oe = 1'b0;
            r_next.ph     = 1'b0;
            r_next.st     = icm_pkg::ST_STOP_END;
          end
        end
      end
      icm_pkg::ST_STOP_END: begin
        if (tick) begin
          r_next.sda_oe = 1'b0;
          r_next.stop   = 1'b0;
          r_next.st     = icm_pkg::ST_IDLE;
          ev[icm_pkg::ST_STOP_DN] = 1'b1;
        end
      end
      default: begin
        r_next.st = icm_pkg::ST_IDLE;
      end
    endcase

    // ----------------------------------------------------------------------
    // Register writes; software sets win over hardware clears
    // ----------------------------------------------------------------------
    if (wr) begin
      case (addr)
        icm_pkg::ADDR_CTRL: begin
          r_next.en    = wdata[icm_pkg::CTL_EN];
          r_next.start = r_next.start | wdata[icm_pkg::CTL_START];
          r_next.stop  = r_next.stop | wdata[icm_pkg::CTL_STOP];
          r_next.nak   = r_next.nak | wdata[icm_pkg::CTL_NAK];
          r_next.baud_timer_irq_enable  = wdata[icm_pkg::CTL_BAUD_TIMER_IRQ_ENABLE];
          r_next.transmit_interrupt_enable   = wdata[icm_pkg::CTL_TXI];
          r_next.fen   = wdata[icm_pkg::CTL_FEN];
          if (wdata[icm_pkg::CTL_FLUSH]) begin
            r_next.data = 8'h00;
            r_next.transmit_empty_flag = 1'b1;
          end
        end
        icm_pkg::ADDR_DATA: begin
          r_next.data = wdata;
          r_next.transmit_empty_flag = 1'b0;
        end
        icm_pkg::ADDR_STATUS: clr = wdata[icm_pkg::EV_W-1:0];
        icm_pkg::ADDR_MASK:   r_next.mask = wdata[icm_pkg::EV_W-1:0];
        icm_pkg::ADDR_BRH:    r_next.brg[BRG_W-1:8] = wdata[BRG_W-9:0];
        icm_pkg::ADDR_BRL:    r_next.brg[7:0] = wdata;
        icm_pkg::ADDR_MODE:   r_next.rx = wdata[icm_pkg::MODE_RX];
        default: begin
        end
      endcase
    end

    // Disabled: bus engine parks and pending start, stop and nak requests are dropped; a written data byte stays pending
    if (!r_next.en) begin
      r_next.st     = icm_pkg::ST_IDLE;
      r_next.sda_oe = 1'b0;
      r_next.scl_oe = 1'b0;
      r_next.start  = 1'b0;
      r_next.stop   = 1'b0;
      r_next.nak    = 1'b0;
      r_next.ph     = 1'b0;
    end

    r_next.status = (r_reg.status & ~clr) | ev;

    if (rd) begin
      case (addr)
        icm_pkg::ADDR_CTRL: begin
          r_next.rdata = {r_reg.en, r_reg.start, r_reg.stop, r_reg.baud_timer_irq_enable,
                          r_reg.transmit_interrupt_enable, r_reg.nak, 1'b0, r_reg.fen};
        end
        icm_pkg::ADDR_DATA:   r_next.rdata = r_reg.rx_byte;
        icm_pkg::ADDR_STATUS: r_next.rdata = {3'h0, r_reg.transmit_empty_flag, r_reg.status};
        icm_pkg::ADDR_MASK:   r_next.rdata = {4'h0, r_reg.mask};
        icm_pkg::ADDR_BRH:    r_next.rdata = r_reg.brg[BRG_W-1:8];
        icm_pkg::ADDR_BRL:    r_next.rdata = r_reg.brg[7:0];
        icm_pkg::ADDR_MODE:   r_next.rdata = {7'h00, r_reg.rx};
        default:              r_next.rdata = 8'h00;
      endcase
    end

    // Transmit request is a level that follows the empty flag while transmit interrupts are enabled
    r_next.dma = r_reg.transmit_interrupt_enable && r_reg.transmit_empty_flag;
    r_next.irq = (|(r_reg.status & r_reg.mask)) || (r_reg.transmit_interrupt_enable && r_reg.transmit_empty_flag);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= RESET_VAL;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign rdata      = r_reg.rdata;
  assign sda_o      = 1'b0;
  assign scl_o      = 1'b0;
  assign sda_oe     = r_reg.sda_oe;
  assign scl_oe     = r_reg.scl_oe;
  assign irq        = r_reg.irq;
  assign dma_tx_req = r_reg.dma;

endmodule : icm_ctrl

// ### bench/icm_ctrl_chk.sv
module icm_ctrl_chk #(
  parameter int BRG_W = 16
) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       ce,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       scl_i,
  input wire logic       scl_o,
  input wire logic       scl_oe,
  input wire logic       irq,
  input wire logic       dma_tx_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------
  // Port checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_ctl_wr(int b, bit v);
    ce && wr && addr == icm_pkg::ADDR_CTRL && wdata[b] == v;
  endsequence
  // One idle cycle after a write, so a following write cannot mask the effect
  sequence s_quiet;
    !wr;
  endsequence
  a_rdata_idle: assert property (!(ce && rd) |=> rdata == 8'h00)
    else $error("read data not zero outside an answer");
  a_unmapped_zero: assert property (ce && rd && addr == 3'h7 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_flush_reads_zero: assert property (
    ce && rd && addr == icm_pkg::ADDR_CTRL |=> !rdata[icm_pkg::CTL_FLUSH])
    else $error("flush bit read as one");
  a_dma_needs_irq: assert property (dma_tx_req |-> irq)
    else $error("dma request without interrupt");
  a_txi_off_quiet: assert property (
    s_ctl_wr(icm_pkg::CTL_TXI, 1'b0) ##1 s_quiet |=> !dma_tx_req)
    else $error("dma request with transmit enable clear");
  a_flush_sets_dma: assert property (
    s_ctl_wr(icm_pkg::CTL_FLUSH, 1'b1) ##0 wdata[icm_pkg::CTL_TXI] ##1 s_quiet
    |=> dma_tx_req)
    else $error("flush did not raise dma request");
  a_data_drops_dma: assert property (
    ce && wr && addr == icm_pkg::ADDR_DATA ##1 s_quiet |=> !dma_tx_req)
    else $error("dma request after data write");
  a_disable_frees: assert property (
    s_ctl_wr(icm_pkg::CTL_EN, 1'b0) |=> !sda_oe && !scl_oe)
    else $error("lines held after disable");
  a_open_drain: assert property (sda_o == 1'b0 && scl_o == 1'b0)
    else $error("pin output value not zero");
endmodule : icm_ctrl_chk

bind icm_ctrl icm_ctrl_chk #(.BRG_W(BRG_W)) icm_ctrl_chk_i (
  .clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oe(scl_oe), .irq(irq), .dma_tx_req(dma_tx_req)
);

// ### bench/icm_slave.sv
module icm_slave (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       rd_mode,
  input  wire logic [7:0] tx_byte,
  output logic            s_oe,
  output int              starts,
  output int              stops,
  output int              ord,
  output logic [7:0]      last_byte,
  output logic            nak_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       scl_q;
  logic       sda_q;
  logic [3:0] cnt;
  logic [7:0] sh;
  // --------------------------------------------------------------------
  // Bus slave, sampled on the system clock; fine at the slow bit rate
  // --------------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {scl_q, sda_q, s_oe, cnt, nak_seen} <= 8'hc0;
      starts <= 0;
      stops  <= 0;
      ord    <= 0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        starts <= starts + 1;
        cnt    <= 4'h0;
      end
      if (scl && scl_q && !sda_q && sda) begin
        stops <= stops + 1;
        s_oe  <= 1'b0;
        if (stops == 0) begin
          ord <= starts;
        end
      end
      if (scl && !scl_q) begin
        sh  <= {sh[6:0], sda};
        cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        if (cnt == 4'h7) begin
          last_byte <= {sh[6:0], sda};
        end
        if (cnt == 4'h8) begin
          nak_seen <= nak_seen | sda;
        end
      end
      // Data changes only while the clock is low, so no false start or stop
      if (!scl && scl_q) begin
        s_oe <= (cnt == 4'h8) ? !rd_mode : rd_mode && !tx_byte[3'h7 - cnt[2:0]];
      end
    end
  end
endmodule : icm_slave

// ### bench/tb_icm_ctrl.sv
module tb_icm_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [2:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } icm_row_t;
  logic       clk;
  logic       arst_n;
  logic       wr;
  logic       rd;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] got;
  logic [7:0] last_byte;
  logic       sda_oe, scl_oe, s_oe, irq, dma_tx_req, rd_mode, nak_seen, ce;
  int         starts, stops, ord, bad_count, comparisons;
  wire        sda = !(sda_oe || s_oe);
  wire        scl = !scl_oe;
  icm_row_t   rows [7] = '{'{icm_pkg::ADDR_MASK, 8'h01, 8'h01},
    '{icm_pkg::ADDR_BRH, 8'h00, 8'h00}, '{icm_pkg::ADDR_BRL, 8'h04, 8'h04},
    '{icm_pkg::ADDR_MODE, 8'h00, 8'h00}, '{3'h7, 8'h55, 8'h00},
    '{icm_pkg::ADDR_CTRL, 8'h03, 8'h01}, '{icm_pkg::ADDR_CTRL, 8'h00, 8'h00}};
  icm_ctrl #(.BRG_W(16)) icm_ctrl_i (
    .clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .scl_i(scl), .scl_o(),
    .scl_oe(scl_oe), .irq(irq), .dma_tx_req(dma_tx_req)
  );
  icm_slave icm_slave_i (
    .clk(clk), .arst_n(arst_n), .scl(scl), .sda(sda), .rd_mode(rd_mode), .tx_byte(8'ha5),
    .s_oe(s_oe), .starts(starts), .stops(stops), .ord(ord), .last_byte(last_byte),
    .nak_seen(nak_seen)
  );
  // --------------------------------------------------------------------
  // Bus tasks and checks
  // --------------------------------------------------------------------
  task automatic put(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : put
  task automatic get(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 got = rdata;
  endtask : get
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask : check
  task automatic end_sim();
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  // Bounded poll; a bus that hangs ends the run here
  task automatic poll(input logic [2:0] a, input logic [7:0] e);
    int n;
    n = 0;
    get(a);
    while (got !== e && n < 500) begin
      get(a);
      n++;
    end
    check("poll", e, got);
    if (got !== e) begin
      end_sim();
    end
  endtask : poll
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {arst_n, wr, rd, addr, wdata, rd_mode} = '0;
    ce = 1'b1;
    bad_count = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    get(icm_pkg::ADDR_CTRL);
    check("ctrl", 8'h00, got);
    get(icm_pkg::ADDR_STATUS);
    check("status", 8'h10, got);
    check("pins", 8'h00, {4'h0, sda_oe, scl_oe, irq, dma_tx_req});
    foreach (rows[i]) begin
      put(rows[i].a, rows[i].d);
      get(rows[i].a);
      check("row", rows[i].e, got);
    end
    put(icm_pkg::ADDR_CTRL, 8'h08);
    tick(2);
    check("txirq", 8'h03, {6'h0, irq, dma_tx_req});
    put(icm_pkg::ADDR_DATA, 8'h11);
    tick(2);
    check("txirq", 8'h00, {6'h0, irq, dma_tx_req});
    put(icm_pkg::ADDR_CTRL, 8'h0a);
    get(icm_pkg::ADDR_STATUS);
    check("flush", 8'h10, got & 8'h10);
    check("txirq", 8'h03, {6'h0, irq, dma_tx_req});
    put(icm_pkg::ADDR_CTRL, 8'h10);
    tick(2);
    // First tick waits for the reset count to run out; the new reload applies after it
    for (int n = 0; n < 70000 && irq !== 1'b1; n++) begin
      tick(1);
    end
    check("baud", 8'h01, 8'(irq));
    if (irq !== 1'b1) begin
      end_sim();
    end
    put(icm_pkg::ADDR_MASK, 8'h00);
    tick(2);
    check("masked", 8'h00, 8'(irq));
    // Clock enable low: the strobe must be ignored
    @(posedge clk);
    ce <= 1'b0;
    put(icm_pkg::ADDR_MASK, 8'h0f);
    ce <= 1'b1;
    get(icm_pkg::ADDR_MASK);
    check("ce", 8'h00, got);
    put(icm_pkg::ADDR_CTRL, 8'h00);
    put(icm_pkg::ADDR_STATUS, 8'h01);
    tick(12);
    get(icm_pkg::ADDR_STATUS);
    check("baud", 8'h00, got & 8'h01);
    put(icm_pkg::ADDR_CTRL, 8'h90);
    tick(12);
    get(icm_pkg::ADDR_STATUS);
    check("baud", 8'h00, got & 8'h01);
    put(icm_pkg::ADDR_CTRL, 8'he4);
    put(icm_pkg::ADDR_CTRL, 8'h80);
    get(icm_pkg::ADDR_CTRL);
    check("held", 8'he4, got);
    check("nostart", 8'h00, 8'(starts));
    put(icm_pkg::ADDR_CTRL, 8'h00);
    get(icm_pkg::ADDR_CTRL);
    check("off", 8'h00, got);
    put(icm_pkg::ADDR_CTRL, 8'hc0);
    put(icm_pkg::ADDR_DATA, 8'ha6);
    poll(icm_pkg::ADDR_CTRL, 8'h80);
    put(icm_pkg::ADDR_DATA, 8'h3c);
    put(icm_pkg::ADDR_CTRL, 8'he0);
    poll(icm_pkg::ADDR_CTRL, 8'h80);
    check("order", 8'h01, 8'(ord));
    check("byte", 8'ha6, last_byte);
    put(icm_pkg::ADDR_CTRL, 8'ha0);
    poll(icm_pkg::ADDR_CTRL, 8'h80);
    check("byte", 8'h3c, last_byte);
    check("stops", 8'h02, 8'(stops));
    check("ack", 8'h00, 8'(nak_seen));
    rd_mode <= 1'b1;
    put(icm_pkg::ADDR_MODE, 8'h01);
    put(icm_pkg::ADDR_DATA, 8'h00);
    put(icm_pkg::ADDR_CTRL, 8'hc4);
    poll(icm_pkg::ADDR_CTRL, 8'h80);
    put(icm_pkg::ADDR_CTRL, 8'ha0);
    poll(icm_pkg::ADDR_CTRL, 8'h80);
    get(icm_pkg::ADDR_DATA);
    check("rx", 8'ha5, got);
    check("nak", 8'h01, 8'(nak_seen));
    end_sim();
  end
endmodule : tb_icm_ctrl
